// ===== inc/lde_map.svh
// register offsets, field positions, reset values and timing counts of the line i/o control
`ifndef LDE_MAP_SVH
`define LDE_MAP_SVH

// ==================================================
// register offsets
`define LDE_ADDR_CTRL       8'h00
`define LDE_ADDR_AUX_CFG    8'h04
`define LDE_ADDR_STATUS     8'h08
`define LDE_ADDR_IRQ_EN     8'h0c
`define LDE_ADDR_LEVELS     8'h10

// ==================================================
// field positions
`define LDE_CTRL_DRV_EN     0
`define LDE_CTRL_INVERT     1
`define LDE_AUX_DO_EN       0
`define LDE_IRQ_W           2
`define LDE_EVT_AUX_EDGE    0
`define LDE_EVT_LINE_EDGE   1
`define LDE_LVL_PWR_GOOD    0
`define LDE_LVL_LINE_DRV    1
`define LDE_LVL_AUX_DRV     2
`define LDE_LVL_TRANSMIT_ENABLE_INPUT        3

// ==================================================
// reset values
`define LDE_RST_DRV_EN      1'b0
`define LDE_RST_INVERT      1'b0
`define LDE_RST_DO_EN       1'b0
`define LDE_RST_IRQ_EN      2'h0

// ==================================================
// timing
`define LDE_CLK_HZ              40000000
`define LDE_PG_RELEASE_US       4000
`define LDE_PG_RELEASE_CYCLES   (`LDE_PG_RELEASE_US * (`LDE_CLK_HZ / 1000000))

`endif

// ===== inc/lde_pkg.sv
// types shared by the line i/o control modules
`include "lde_map.svh"

package lde_pkg;

    // ==================================================
    // power good sequencer
    typedef enum logic [1:0] {
        PG_HOLD  = 2'b00,
        PG_COUNT = 2'b01,
        PG_GOOD  = 2'b11
    } pg_state_t;

    typedef struct packed {
        pg_state_t   state;
        logic [31:0] cnt;
        logic        hold;
    } pg_regs_t;

    // ==================================================
    // auxiliary pin pair
    typedef struct packed {
        logic line_o;
        logic line_oe;
        logic logic_o;
        logic logic_oe;
    } aux_regs_t;

    // ==================================================
    // top level state
    typedef struct packed {
        logic                  drv_en;
        logic                  invert;
        logic                  do_en;
        logic [`LDE_IRQ_W-1:0] status;
        logic [`LDE_IRQ_W-1:0] irq_en;
        logic [31:0]           rdata;
        logic                  line_drv;
        logic                  line_oe;
        logic                  rx;
        logic                  irq_oe;
        logic                  line_prev;
        logic                  aux_prev;
    } top_regs_t;

endpackage

// ===== src/aux_pin_path.sv
// direction and inversion of the auxiliary line / auxiliary logic pin pair
`timescale 1ns/1ps
`default_nettype none

module aux_pin_path (
    input  wire logic clk_i,           // 40 MHz clock
    input  wire logic rst_i,           // async reset, active high
    input  wire logic in_reset_i,      // device held in reset
    input  wire logic do_en_i,         // 1: line is an output
    input  wire logic aux_line_in_i,   // sensed aux line level
    input  wire logic aux_logic_in_i,  // sensed aux logic level
    output logic      aux_line_o,      // aux line drive level
    output logic      aux_line_oe_o,   // aux line driver on
    output logic      aux_logic_o,     // aux logic drive level
    output logic      aux_logic_oe_o   // aux logic pin driven
);

    lde_pkg::aux_regs_t st_r;
    lde_pkg::aux_regs_t st_nxt;

    // ==================================================
    // pin pair
    always_comb begin
        st_nxt          = '0;
        if (in_reset_i) begin
            st_nxt = '0;
        end else if (do_en_i) begin
            st_nxt.line_oe  = 1'b1;
            st_nxt.line_o   = ~aux_logic_in_i;
        end else begin
            st_nxt.logic_oe = 1'b1;
            st_nxt.logic_o  = ~aux_line_in_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign aux_line_o     = st_r.line_o;
    assign aux_line_oe_o  = st_r.line_oe;
    assign aux_logic_o    = st_r.logic_o;
    assign aux_logic_oe_o = st_r.logic_oe;

endmodule

`default_nettype wire

// ===== src/line_io_ctrl.sv
// pin level control of a dual driver line transceiver: drivers, aux pins, irq, reset pin
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "lde_map.svh"

module line_io_ctrl #(
    parameter int unsigned RELEASE_CYCLES = `LDE_PG_RELEASE_CYCLES,
    parameter int unsigned ADDR_W         = 8
) (
    input  wire logic              clk_i,            // 40 MHz clock
    input  wire logic              rst_i,            // async reset, active high
    input  wire logic [ADDR_W-1:0] addr_i,           // register byte address
    input  wire logic [31:0]       wdata_i,          // write data
    input  wire logic              wr_i,             // write strobe
    input  wire logic              rd_i,             // read strobe
    output logic      [31:0]       rdata_o,          // read data, cycle after rd_i
    input  wire logic              tx_i,             // transmit data from uart
    input  wire logic              transmit_enable_input_i,           // transmit enable input
    input  wire logic              line_in_i,        // sensed main line level
    output logic                   line_drv_o,       // main line drive level
    output logic                   line_drv_oe_o,    // main line driver on
    output logic                   rx_o,             // receive data to uart
    input  wire logic              aux_line_in_i,    // sensed aux line level
    output logic                   aux_line_o,       // aux line drive level
    output logic                   aux_line_oe_o,    // aux line driver on
    input  wire logic              aux_logic_in_i,   // sensed aux logic pin
    output logic                   aux_logic_o,      // aux logic drive level
    output logic                   aux_logic_oe_o,   // aux logic pin driven
    output logic                   irq_n_o,          // irq pin level when driven
    output logic                   irq_oe_o,         // irq pin pulled low
    input  wire logic              rst_pin_in_i,     // sensed reset pin level
    output logic                   rst_pin_out_o,    // reset pin level when driven
    output logic                   rst_pin_oe_o,     // reset pin pulled low
    input  wire logic              line_supply_ok_i, // line supply above lockout
    input  wire logic              five_volt_ok_i,   // 5 V supply above lockout
    input  wire logic              buck_ok_i,        // buck output above lockout
    input  wire logic              buck_on_i         // buck converter enabled
);

    generate
        if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
            $error("line_io_ctrl: ADDR_W must be 5..32");
        end
    endgenerate

    localparam int unsigned W = `LDE_IRQ_W;

    lde_pkg::top_regs_t st_r;
    lde_pkg::top_regs_t st_nxt;
    logic               dev_reset;
    logic               pg_hold;
    logic [W-1:0]       events;
    logic [W-1:0]       w1c;
    logic [31:0]        rd_mux;

    // ==================================================
    // reset pin
    // the pin is sensed, not our own pull, so an outside pull and our
    // power good pull act alike
    assign dev_reset = ~rst_pin_in_i;

    power_good_seq #(
        .RELEASE_CYCLES(RELEASE_CYCLES)
    ) u_pg (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .line_supply_ok_i(line_supply_ok_i),
        .five_volt_ok_i  (five_volt_ok_i),
        .buck_ok_i       (buck_ok_i),
        .buck_on_i       (buck_on_i),
        .hold_o          (pg_hold)
    );

    // open-drain: data is always low, only the enable moves
    assign rst_pin_out_o = 1'b0;
    assign rst_pin_oe_o  = pg_hold;
    assign irq_n_o       = 1'b0;

    // ==================================================
    // aux pin pair
    aux_pin_path u_aux (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .in_reset_i    (dev_reset),
        .do_en_i       (st_r.do_en),
        .aux_line_in_i (aux_line_in_i),
        .aux_logic_in_i(aux_logic_in_i),
        .aux_line_o    (aux_line_o),
        .aux_line_oe_o (aux_line_oe_o),
        .aux_logic_o   (aux_logic_o),
        .aux_logic_oe_o(aux_logic_oe_o)
    );

    // ==================================================
    // register bus
    always_comb begin
        rd_mux = 32'h0;
        if (addr_i == ADDR_W'(`LDE_ADDR_CTRL)) begin
            rd_mux[`LDE_CTRL_DRV_EN] = st_r.drv_en;
            rd_mux[`LDE_CTRL_INVERT] = st_r.invert;
        end else if (addr_i == ADDR_W'(`LDE_ADDR_AUX_CFG)) begin
            rd_mux[`LDE_AUX_DO_EN] = st_r.do_en;
        end else if (addr_i == ADDR_W'(`LDE_ADDR_STATUS)) begin
            rd_mux[W-1:0] = st_r.status;
        end else if (addr_i == ADDR_W'(`LDE_ADDR_IRQ_EN)) begin
            rd_mux[W-1:0] = st_r.irq_en;
        end else if (addr_i == ADDR_W'(`LDE_ADDR_LEVELS)) begin
            rd_mux[`LDE_LVL_PWR_GOOD] = ~pg_hold;
            rd_mux[`LDE_LVL_LINE_DRV] = st_r.line_oe;
            rd_mux[`LDE_LVL_AUX_DRV]  = aux_line_oe_o;
            rd_mux[`LDE_LVL_TRANSMIT_ENABLE_INPUT]     = transmit_enable_input_i;
        end
    end

    assign w1c = (wr_i && addr_i == ADDR_W'(`LDE_ADDR_STATUS)) ? wdata_i[W-1:0] : '0;

    // ==================================================
    // events
    // aux edge only counts while the aux line is an input; line edge only
    // while our own driver is off, so our own transmit does not echo
    assign events[`LDE_EVT_AUX_EDGE]  = ~st_r.do_en & (aux_line_in_i ^ st_r.aux_prev);
    assign events[`LDE_EVT_LINE_EDGE] = ~st_r.line_oe & (line_in_i ^ st_r.line_prev);

    // ==================================================
    // next state
    always_comb begin
        st_nxt           = st_r;
        st_nxt.line_prev = line_in_i;
        st_nxt.aux_prev  = aux_line_in_i;
        st_nxt.rdata     = rd_i ? rd_mux : 32'h0;
        if (wr_i) begin
            if (addr_i == ADDR_W'(`LDE_ADDR_CTRL)) begin
                st_nxt.drv_en = wdata_i[`LDE_CTRL_DRV_EN];
                st_nxt.invert = wdata_i[`LDE_CTRL_INVERT];
            end else if (addr_i == ADDR_W'(`LDE_ADDR_AUX_CFG)) begin
                st_nxt.do_en = wdata_i[`LDE_AUX_DO_EN];
            end else if (addr_i == ADDR_W'(`LDE_ADDR_IRQ_EN)) begin
                st_nxt.irq_en = wdata_i[W-1:0];
            end
        end
        // a new event beats a clear in the same cycle
        st_nxt.status = (st_r.status & ~w1c) | events;
        st_nxt.irq_oe = |(st_r.status & st_r.irq_en);
        st_nxt.line_oe  = st_r.drv_en & transmit_enable_input_i;
        st_nxt.line_drv = st_r.invert ? tx_i : ~tx_i;
        st_nxt.rx       = st_r.invert ? line_in_i : ~line_in_i;
        if (dev_reset) begin
            st_nxt.drv_en  = `LDE_RST_DRV_EN;
            st_nxt.invert  = `LDE_RST_INVERT;
            st_nxt.do_en   = `LDE_RST_DO_EN;
            st_nxt.irq_en  = `LDE_RST_IRQ_EN;
            st_nxt.status  = '0;
            st_nxt.irq_oe  = 1'b0;
            st_nxt.line_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================
    // outputs
    assign rdata_o       = st_r.rdata;
    assign line_drv_o    = st_r.line_drv;
    assign line_drv_oe_o = st_r.line_oe;
    assign rx_o          = st_r.rx;
    assign irq_oe_o      = st_r.irq_oe;

    // ==================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_aux_off_default;
        !st_r.do_en |=> !aux_line_oe_o;
    endproperty
    a_aux_off_default: assert property (p_aux_off_default) else $error("aux driver on");

    property p_aux_dir;
        (st_r.do_en && rst_pin_in_i) |=> (aux_line_oe_o && !aux_logic_oe_o);
    endproperty
    a_aux_dir: assert property (p_aux_dir) else $error("aux direction wrong");

    property p_main_needs_both;
        line_drv_oe_o |-> $past(st_r.drv_en && transmit_enable_input_i && rst_pin_in_i);
    endproperty
    a_main_needs_both: assert property (p_main_needs_both) else $error("main driver on");

    property p_main_on;
        (st_r.drv_en && transmit_enable_input_i && rst_pin_in_i) |=> line_drv_oe_o;
    endproperty
    a_main_on: assert property (p_main_on) else $error("main driver not on");

    property p_transmit_enable_input_off;
        !transmit_enable_input_i |=> !line_drv_oe_o;
    endproperty
    a_transmit_enable_input_off: assert property (p_transmit_enable_input_off) else $error("driver on without enable");

    property p_irq;
        (|(st_r.status & st_r.irq_en) && rst_pin_in_i) |=> irq_oe_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not pulled low");

    property p_pin_reset;
        !rst_pin_in_i |=> (!st_r.drv_en && !st_r.do_en && st_r.irq_en == '0 && !line_drv_oe_o);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

    property p_undervoltage_lockout;
        !five_volt_ok_i |=> rst_pin_oe_o;
    endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("undervoltage not pulled");

    property p_release_cause;
        $fell(rst_pin_oe_o)
            |-> $past(five_volt_ok_i && (!buck_on_i || (line_supply_ok_i && buck_ok_i)));
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("bad release");

    property p_logic_out;
        (!st_r.do_en && rst_pin_in_i) |=> (aux_logic_oe_o && aux_logic_o == !$past(aux_line_in_i));
    endproperty
    a_logic_out: assert property (p_logic_out) else $error("aux logic output wrong");

    property p_line_from_logic;
        (st_r.do_en && rst_pin_in_i) |=> (aux_line_o == !$past(aux_logic_in_i));
    endproperty
    a_line_from_logic: assert property (p_line_from_logic) else $error("aux line wrong");

    property p_rx;
        1'b1 |=> rx_o == ($past(st_r.invert) ? $past(line_in_i) : !$past(line_in_i));
    endproperty
    a_rx: assert property (p_rx) else $error("receive polarity wrong");

    c_transmit: cover property (st_r.drv_en && transmit_enable_input_i ##1 line_drv_oe_o);
    c_aux_output: cover property (st_r.do_en ##1 aux_line_oe_o);
    c_irq: cover property ($rose(irq_oe_o));
    c_release: cover property ($fell(rst_pin_oe_o));

endmodule

`default_nettype wire

// ===== src/power_good_seq.sv
// undervoltage monitor and release delay behind the reset / power good pin
`timescale 1ns/1ps
`default_nettype none
`include "lde_map.svh"

module power_good_seq #(
    parameter int unsigned RELEASE_CYCLES = `LDE_PG_RELEASE_CYCLES
) (
    input  wire logic clk_i,           // 40 MHz clock
    input  wire logic rst_i,           // async reset, active high
    input  wire logic line_supply_ok_i, // line supply above lockout
    input  wire logic five_volt_ok_i,  // 5 V supply above lockout
    input  wire logic buck_ok_i,       // buck output above lockout
    input  wire logic buck_on_i,       // buck converter enabled
    output logic      hold_o           // pull the reset pin low
);

    generate
        if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > 32'h7fffffff) begin : g_chk
            $error("power_good_seq: RELEASE_CYCLES out of range");
        end
    endgenerate

    localparam logic [31:0] LAST = 32'(RELEASE_CYCLES - 1);

    lde_pkg::pg_regs_t st_r;
    lde_pkg::pg_regs_t st_nxt;
    logic              all_ok;

    // ==================================================
    // sequencer
    // with the buck off only the 5 V rail counts
    assign all_ok = five_volt_ok_i & (~buck_on_i | (line_supply_ok_i & buck_ok_i));

    always_comb begin
        st_nxt = st_r;
        unique case (st_r.state)
            lde_pkg::PG_HOLD: begin
                st_nxt.cnt = 32'h0;
                if (all_ok) begin
                    st_nxt.state = lde_pkg::PG_COUNT;
                end
            end
            lde_pkg::PG_COUNT: begin
                if (!all_ok) begin
                    st_nxt.state = lde_pkg::PG_HOLD;
                    st_nxt.cnt   = 32'h0;
                end else if (st_r.cnt == LAST) begin
                    st_nxt.state = lde_pkg::PG_GOOD;
                    st_nxt.hold  = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                end
            end
            lde_pkg::PG_GOOD: begin
                if (!all_ok) begin
                    st_nxt.state = lde_pkg::PG_HOLD;
                    st_nxt.hold  = 1'b1;
                end
            end
            default: begin
                st_nxt.state = lde_pkg::PG_HOLD;
                st_nxt.hold  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{state: lde_pkg::PG_HOLD, cnt: 32'h0, hold: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hold_o = st_r.hold;

    // ==================================================
    // checks
    property p_release_count;
        @(posedge clk_i) disable iff (rst_i)
        $fell(st_r.hold) |-> $past(st_r.cnt) == LAST;
    endproperty
    a_release_count: assert property (p_release_count) else $error("early power good release");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.state == lde_pkg::PG_COUNT && !all_ok) |=> (st_r.cnt == 32'h0 && st_r.hold);
    endproperty
    a_restart: assert property (p_restart) else $error("release delay not restarted");

endmodule

`default_nettype wire

// ===== verification/host_mcu_model.sv
// host side of the pins: open-drain reset and irq wires with pull-ups
`timescale 1ns/1ps
`default_nettype none

module host_mcu_model (
    input  wire logic ext_pull_i,    // host pulls reset pin low
    input  wire logic rst_pin_oe_i,  // device pulls reset pin low
    input  wire logic irq_oe_i,      // device pulls irq pin low
    output logic      rst_pin_o,     // resolved reset wire
    output logic      irq_pin_o      // resolved irq wire
);
    // pull-ups: a released wire rises, it never keeps a stale level
    assign rst_pin_o = !(ext_pull_i || rst_pin_oe_i);
    assign irq_pin_o = !irq_oe_i;
endmodule

`default_nettype wire

// ===== verification/line_io_ctrl_tb_top.sv
// self-checking bench of the line i/o control block
`timescale 1ns/1ps
`default_nettype none
`include "lde_map.svh"

module line_io_ctrl_tb_top;
    localparam int R = 8;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o;
    logic [31:0] v;
    logic        wr_i = 1'b0, rd_i = 1'b0, tx_i = 1'b0, transmit_enable_input_i = 1'b0, line_in_i = 1'b0;
    logic        aux_line_in_i = 1'b0, aux_logic_in_i = 1'b0, buck_on_i = 1'b1, ext_pull = 1'b0;
    logic [2:0]  sup_ok = 3'h0;
    logic        line_drv_o, line_drv_oe_o, rx_o, aux_line_o, aux_line_oe_o, aux_logic_o;
    logic        aux_logic_oe_o, irq_n_o, irq_oe_o, rst_pin_out_o, rst_pin_oe_o, rst_pin, irq_pin;
    logic [15:0] lfsr_r = 16'h9c1a;
    logic        m_drv, m_inv, m_doen, e_oe, e_drv, e_rx, e_rxv, e_al, e_aloe, e_lg, e_lgoe;
    logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h0c, 8'h14, 8'h10};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    int          num_errors = 0;
    int          checked = 0;
    int          n;

    always #12.5 clk_i = ~clk_i;

    line_io_ctrl #(.RELEASE_CYCLES(R), .ADDR_W(8)) u_line_io_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .tx_i(tx_i), .transmit_enable_input_i(transmit_enable_input_i), .line_in_i(line_in_i),
        .line_drv_o(line_drv_o), .line_drv_oe_o(line_drv_oe_o), .rx_o(rx_o),
        .aux_line_in_i(aux_line_in_i), .aux_line_o(aux_line_o), .aux_line_oe_o(aux_line_oe_o),
        .aux_logic_in_i(aux_logic_in_i), .aux_logic_o(aux_logic_o),
        .aux_logic_oe_o(aux_logic_oe_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o),
        .rst_pin_in_i(rst_pin), .rst_pin_out_o(rst_pin_out_o), .rst_pin_oe_o(rst_pin_oe_o),
        .line_supply_ok_i(sup_ok[1]), .five_volt_ok_i(sup_ok[0]), .buck_ok_i(sup_ok[2]),
        .buck_on_i(buck_on_i));

    host_mcu_model u_host_mcu_model (.ext_pull_i(ext_pull), .rst_pin_oe_i(rst_pin_oe_o),
        .irq_oe_i(irq_oe_o), .rst_pin_o(rst_pin), .irq_pin_o(irq_pin));

    // ====================================
    // random traffic on the pins no scenario owns
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    always @(posedge clk_i) begin
        lfsr_r <= lfsr_next(lfsr_r);
        tx_i <= lfsr_r[0];
        line_in_i <= lfsr_r[3];
        aux_logic_in_i <= lfsr_r[7];
    end

    // ====================================
    // reference model: one cycle from inputs to pins
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {m_drv, m_inv, m_doen, e_oe, e_rxv, e_aloe, e_lgoe} = 7'h0;
        end else begin
            e_oe = rst_pin & m_drv & transmit_enable_input_i;
            e_drv = m_inv ? tx_i : !tx_i;
            e_rx = m_inv ? line_in_i : !line_in_i;
            e_rxv = rst_pin;
            e_aloe = rst_pin & m_doen;
            e_al = !aux_logic_in_i;
            e_lgoe = rst_pin & !m_doen;
            e_lg = !aux_line_in_i;
            if (!rst_pin) begin
                {m_drv, m_inv, m_doen} = 3'h0;
            end else if (wr_i && addr_i == `LDE_ADDR_CTRL) begin
                {m_inv, m_drv} = wdata_i[1:0];
            end else if (wr_i && addr_i == `LDE_ADDR_AUX_CFG) begin
                m_doen = wdata_i[0];
            end
        end
    end

    always @(negedge clk_i) begin
        if (!rst_i) begin
            check(line_drv_oe_o, e_oe);
            check({irq_n_o, rst_pin_out_o}, 2'b00);
            if (e_oe) check(line_drv_o, e_drv);
            if (e_rxv) check(rx_o, e_rx);
            check(aux_line_oe_o, e_aloe);
            if (e_aloe) check(aux_line_o, e_al);
            check(aux_logic_oe_o, e_lgoe);
            if (e_lgoe) check(aux_logic_o, e_lg);
        end
    end

    // ====================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // cycles until the device lets go of the reset pin, bounded
    task automatic pg_wait(output int c);
        c = 0;
        while (rst_pin_oe_o !== 1'b0) begin
            @(posedge clk_i);
            #1 c++;
            if (c > 4 * R) begin
                num_errors++;
                end_sim();
            end
        end
    endtask

    task automatic drop(input int i);
        @(posedge clk_i);
        sup_ok[i] <= 1'b0;
        @(posedge clk_i);
        sup_ok[i] <= 1'b1;
        #1 check(rst_pin_oe_o, 1'b1);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        end_sim();
    end

    // ====================================
    // scenarios
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        sup_ok <= 3'h7;
        pg_wait(n);
        check(n >= R + 1 && n <= R + 2, 1'b1);
        for (int i = 0; i < 3; i++) begin
            drop(i);
            repeat (R / 2) @(posedge clk_i);
            drop(i);
            pg_wait(n);
            check(n >= R + 1 && n <= R + 2, 1'b1);
        end
        $display("power good release done");
        @(posedge clk_i);
        buck_on_i <= 1'b0;
        sup_ok <= 3'h1;
        repeat (R + 4) @(posedge clk_i);
        #1 check(rst_pin_oe_o, 1'b0);
        drop(0);
        pg_wait(n);
        check(n >= R + 1 && n <= R + 2, 1'b1);
        @(posedge clk_i);
        sup_ok <= 3'h7;
        @(posedge clk_i);
        buck_on_i <= 1'b1;
        $display("buck off monitoring done");
        for (int i = 0; i < 5; i++) begin
            bus_rd(ra[i], v);
            check(v, rv[i]);
        end
        for (int k = 0; k < 8; k++) begin
            bus_wr(`LDE_ADDR_CTRL, k / 2);
            transmit_enable_input_i <= k[0];
            repeat (6) @(posedge clk_i);
            bus_rd(`LDE_ADDR_CTRL, v);
            check(v, k / 2);
        end
        @(posedge clk_i);
        transmit_enable_input_i <= 1'b0;
        $display("main driver done");
        for (int d = 0; d < 2; d++) begin
            bus_wr(`LDE_ADDR_AUX_CFG, d);
            repeat (4) @(posedge clk_i) aux_line_in_i <= !aux_line_in_i;
            bus_rd(`LDE_ADDR_AUX_CFG, v);
            check(v, d);
        end
        $display("aux direction done");
        bus_wr(`LDE_ADDR_AUX_CFG, 32'h0);
        bus_wr(`LDE_ADDR_STATUS, 32'h3);
        @(posedge clk_i) aux_line_in_i <= !aux_line_in_i;
        repeat (3) @(posedge clk_i);
        #1 check(irq_pin, 1'b1);
        bus_rd(`LDE_ADDR_STATUS, v);
        check(v[0], 1'b1);
        bus_wr(`LDE_ADDR_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk_i);
        #1 check(irq_pin, 1'b0);
        bus_wr(`LDE_ADDR_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        #1 check(irq_pin, 1'b1);
        $display("interrupt done");
        bus_wr(`LDE_ADDR_CTRL, 32'h3);
        bus_wr(`LDE_ADDR_AUX_CFG, 32'h1);
        bus_wr(`LDE_ADDR_IRQ_EN, 32'h1);
        transmit_enable_input_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus_rd(`LDE_ADDR_LEVELS, v);
        check(v, 32'hf);
        @(posedge clk_i);
        ext_pull <= 1'b1;
        bus_wr(`LDE_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        #1 check(rst_pin_oe_o, 1'b0);
        @(posedge clk_i);
        ext_pull <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus_rd(ra[i], v);
            check(v, 32'h0);
        end
        $display("pin reset done");
        end_sim();
    end
endmodule

`default_nettype wire
